// >>> core/att_pkg.sv
// Constants and types of the autotune teach sequencer.
package att_pkg;

  // System clock rate and the derived millisecond tick.
  localparam int CLK_HZ   = 32'h0773_5940;
  localparam int MS_PER_S = 32'h0000_03E8;
  localparam int TICK_CYC = CLK_HZ / MS_PER_S;

  // Hold, wait and blink times in milliseconds.
  localparam logic [15:0] T_MODE_MS  = 16'h09C4;
  localparam logic [15:0] T_START_MS = 16'h01F4;
  localparam logic [15:0] T_ARM_MS   = 16'h2710;
  localparam logic [15:0] T_WAIT_MS  = 16'h2710;
  localparam logic [15:0] T_EXT_MS   = 16'h1388;
  localparam logic [15:0] T_CLOSE_MS = 16'h3A98;
  localparam logic [15:0] T_LED_M_MS = 16'h01F4;
  localparam logic [15:0] T_LED_R_MS = 16'h00C8;
  localparam logic [15:0] T_DEB_MS   = 16'h0014;

  // Register offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TOL    = 8'h08;
  localparam logic [7:0] OFF_ISTAT  = 8'h0C;
  localparam logic [7:0] OFF_ICLR   = 8'h10;
  localparam logic [7:0] OFF_IEN    = 8'h14;
  localparam logic [7:0] OFF_TGT_A  = 8'h18;
  localparam logic [7:0] OFF_TGT_B  = 8'h1C;
  localparam logic [7:0] OFF_TGT_C  = 8'h20;
  localparam logic [7:0] OFF_TGT_D  = 8'h24;

  // Command bits of the control register.
  localparam int CTRL_MODE  = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_RESET = 2;

  // Event bits of the interrupt registers.
  localparam int EV_DONE  = 0;
  localparam int EV_TMO   = 1;
  localparam int EV_WRONG = 2;
  localparam int EV_RESET = 3;

  // Reset values and codes.
  localparam logic [15:0] TOL_RST     = 16'h0008;
  localparam logic [1:0]  SINGLE_SEAT = 2'h2;

  typedef enum logic [7:0] {
    ATT_IDLE  = 8'h01,
    ATT_ARMED = 8'h02,
    ATT_OPEN  = 8'h04,
    ATT_CL1   = 8'h08,
    ATT_UP    = 8'h10,
    ATT_CL2   = 8'h20,
    ATT_LO    = 8'h40,
    ATT_CL3   = 8'h80
  } att_state_t;

endpackage : att_pkg

// >>> core/att_debounce.sv
// Input synchroniser and debouncer for the teach buttons.
`timescale 1ns/1ps
module att_debounce #(
  parameter int N = 3
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Millisecond tick.
  input  wire logic         tick,
  // Raw and clean levels.
  input  wire logic [N-1:0] raw,
  output logic [N-1:0]      clean
);

  typedef struct packed {
    logic [N-1:0]       s1;
    logic [N-1:0]       s2;
    logic [N-1:0]       lvl;
    logic [N-1:0][15:0] cnt;
  } att_deb_t;

  att_deb_t r_ff;
  att_deb_t nxt_r;

  always_comb
  begin
    nxt_r    = r_ff;
    nxt_r.s1 = raw;
    nxt_r.s2 = r_ff.s1;
    for (int i = 0; i < N; i++)
    begin
      if (r_ff.s2[i] == r_ff.lvl[i])
        nxt_r.cnt[i] = 16'h0000;
      else if (tick && r_ff.cnt[i] == att_pkg::T_DEB_MS - 16'h0001)
      begin
        nxt_r.lvl[i] = r_ff.s2[i];
        nxt_r.cnt[i] = 16'h0000;
      end
      else if (tick)
        nxt_r.cnt[i] = r_ff.cnt[i] + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  assign clean = r_ff.lvl;

endmodule : att_debounce

// >>> core/att_sequencer.sv
// Autotune teach sequencer for a process valve position unit.
// Function
// - Buttons b and c held 2.5 s enter autotune.
// - Button a held 0.5 s starts teach.
// - No start within 10 s leaves autotune.
// - Latch closed, open pilot a, wait, latch open.
// - Motion at wait end adds 5 s.
// - Release pilot a, await closure within 15 s.
// - Single-seat finishes after closing, else seats follow.
// - Upper seat via pilot b, latch, close.
// - Lower seat via pilot c, latch, close.
// - Lower seat checks valve-type selection.
// - Closure timeout or wrong selection aborts.
// - Abort clears targets and shows fault.
// - Buttons a and b 2.5 s clear targets unless a teach is running.
// - Valve state derived from four target flags.
// - Service requests act like button presses.
// - Target reached only inside tolerance band.
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
module att_sequencer #(
  parameter int SW       = 10,
  parameter int TICK_CYC = att_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  // Teach buttons and valve-type switches.
  input  wire logic          teach_button_a,
  input  wire logic          teach_button_b,
  input  wire logic          teach_button_c,
  input  wire logic          valve_type_switch_lo,
  input  wire logic          valve_type_switch_hi,
  // Position sensor readings.
  input  wire logic [SW-1:0] pos_ext,
  input  wire logic [SW-1:0] pos_int,
  // Register port.
  input  wire logic [7:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  // Pilot valves.
  output logic               pilot_output_a,
  output logic               pilot_output_b,
  output logic               pilot_output_c,
  // Position feedback.
  output logic               target_pos_a,
  output logic               target_pos_b,
  output logic               target_pos_c,
  output logic               target_pos_d,
  output logic [1:0]         valve_state,
  // Indicator and interrupt.
  output logic [2:0]         status_indicator,
  output logic               irq
);

  typedef struct packed {
    att_pkg::att_state_t st;
    logic [16:0]         tick;
    logic [15:0]         tmr;
    logic                ext;
    logic                moved;
    logic [15:0]         h_mode;
    logic [15:0]         h_start;
    logic [15:0]         h_rst;
    logic [1:0]          vt_s1;
    logic [1:0]          vt_s2;
    logic [3:0]          taught;
    logic [SW-1:0]       ta;
    logic [SW-1:0]       tb;
    logic [SW-1:0]       tc;
    logic [SW-1:0]       td;
    logic [SW-1:0]       prev_ext;
    logic [SW-1:0]       prev_int;
    logic [SW-1:0]       tol;
    logic [2:0]          pilot;
    logic                err;
    logic [3:0]          reach;
    logic [1:0]          vstate;
    logic [15:0]         ledc;
    logic [1:0]          ph;
    logic                bl;
    logic [2:0]          led;
    logic [3:0]          ist;
    logic [3:0]          ien;
    logic [31:0]         rdata;
  } att_seq_t;

  att_seq_t r_ff;
  att_seq_t nxt_r;

  logic [2:0]  btn;
  logic        tick;
  logic        svc_mode;
  logic        svc_start;
  logic        svc_rst;
  logic        mode_req;
  logic        start_req;
  logic        rst_req;
  logic        run;
  logic        wexp;
  logic        extend;
  logic        closed;
  logic        closing;
  logic        abort;
  logic        wrong;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic [15:0] per;

  function automatic logic in_band(logic [SW-1:0] x, logic [SW-1:0] t,
                                   logic [SW-1:0] tol);
    logic [SW-1:0] d;
    d = (x > t) ? x - t : t - x;
    return d <= tol;
  endfunction : in_band

  function automatic logic [15:0] hold_nxt(logic on, logic tk, logic [15:0] h,
                                           logic [15:0] lim);
    if (!on)
      return 16'h0000;
    if (tk && h != lim)
      return h + 16'h0001;
    return h;
  endfunction : hold_nxt

  att_debounce #(
    .N (3)
  ) u_deb (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick),
    .raw     ({teach_button_c, teach_button_b, teach_button_a}),
    .clean   (btn)
  );

  assign tick = r_ff.tick == 17'(TICK_CYC - 1);

  assign svc_mode  = reg_wr && reg_addr == att_pkg::OFF_CTRL
                     && reg_wdata[att_pkg::CTRL_MODE];
  assign svc_start = reg_wr && reg_addr == att_pkg::OFF_CTRL
                     && reg_wdata[att_pkg::CTRL_START];
  assign svc_rst   = reg_wr && reg_addr == att_pkg::OFF_CTRL
                     && reg_wdata[att_pkg::CTRL_RESET];
  assign clr = (reg_wr && reg_addr == att_pkg::OFF_ICLR) ? reg_wdata[3:0] : 4'h0;

  assign mode_req  = svc_mode || (btn[1] && btn[2] && tick
                     && r_ff.h_mode == att_pkg::T_MODE_MS - 16'h0001);
  assign start_req = svc_start || (btn[0] && !btn[1] && !btn[2] && tick
                     && r_ff.h_start == att_pkg::T_START_MS - 16'h0001);
  assign rst_req   = svc_rst || (btn[0] && btn[1] && tick
                     && r_ff.h_rst == att_pkg::T_MODE_MS - 16'h0001);

  assign run     = !(r_ff.st inside {att_pkg::ATT_IDLE, att_pkg::ATT_ARMED});
  assign wexp    = r_ff.tmr == (r_ff.ext ? att_pkg::T_EXT_MS : att_pkg::T_WAIT_MS);
  assign extend  = wexp && !r_ff.ext && r_ff.moved;
  assign closed  = in_band(pos_ext, r_ff.ta, r_ff.tol);
  assign closing = r_ff.st inside {att_pkg::ATT_CL1, att_pkg::ATT_CL2, att_pkg::ATT_CL3};
  assign per     = (r_ff.st == att_pkg::ATT_ARMED) ? att_pkg::T_LED_M_MS
                                                   : att_pkg::T_LED_R_MS;

  always_comb
  begin
    nxt_r         = r_ff;
    abort         = 1'b0;
    wrong         = 1'b0;
    ev            = 4'h0;
    nxt_r.tick    = tick ? 17'h0_0000 : r_ff.tick + 17'h0_0001;
    nxt_r.vt_s1   = {valve_type_switch_hi, valve_type_switch_lo};
    nxt_r.vt_s2   = r_ff.vt_s1;
    nxt_r.h_mode  = hold_nxt(btn[1] && btn[2], tick, r_ff.h_mode, att_pkg::T_MODE_MS);
    nxt_r.h_start = hold_nxt(btn[0] && !btn[1] && !btn[2], tick, r_ff.h_start,
                             att_pkg::T_START_MS);
    nxt_r.h_rst   = hold_nxt(btn[0] && btn[1], tick, r_ff.h_rst, att_pkg::T_MODE_MS);
    if (tick)
    begin
      nxt_r.tmr      = r_ff.tmr + 16'h0001;
      nxt_r.prev_ext = pos_ext;
      nxt_r.prev_int = pos_int;
      nxt_r.moved    = !in_band(pos_ext, r_ff.prev_ext, r_ff.tol)
                       || !in_band(pos_int, r_ff.prev_int, r_ff.tol);
    end
    if (extend)
    begin
      nxt_r.ext = 1'b1;
      nxt_r.tmr = 16'h0000;
    end
    case (r_ff.st)
      att_pkg::ATT_IDLE:
        if (mode_req)
          nxt_r.st = att_pkg::ATT_ARMED;
      att_pkg::ATT_ARMED:
        if (r_ff.tmr == att_pkg::T_ARM_MS)
          nxt_r.st = att_pkg::ATT_IDLE;
        else if (start_req)
        begin
          nxt_r.ta     = pos_ext;
          nxt_r.taught = 4'h1;
          nxt_r.err    = 1'b0;
          nxt_r.pilot  = 3'b001;
          nxt_r.st     = att_pkg::ATT_OPEN;
        end
      att_pkg::ATT_OPEN:
        if (wexp && !extend)
        begin
          nxt_r.tb        = pos_ext;
          nxt_r.taught[1] = 1'b1;
          nxt_r.pilot     = 3'b000;
          nxt_r.st        = att_pkg::ATT_CL1;
        end
      att_pkg::ATT_CL1:
        if (closed)
        begin
          if (r_ff.vt_s2 == att_pkg::SINGLE_SEAT)
          begin
            nxt_r.st          = att_pkg::ATT_IDLE;
            ev[att_pkg::EV_DONE] = 1'b1;
          end
          else
          begin
            nxt_r.pilot = 3'b010;
            nxt_r.st    = att_pkg::ATT_UP;
          end
        end
        else if (r_ff.tmr == att_pkg::T_CLOSE_MS)
          abort = 1'b1;
      att_pkg::ATT_UP:
        if (wexp && !extend)
        begin
          nxt_r.tc        = pos_int;
          nxt_r.taught[2] = 1'b1;
          nxt_r.pilot     = 3'b000;
          nxt_r.st        = att_pkg::ATT_CL2;
        end
      att_pkg::ATT_CL2:
        if (closed)
        begin
          nxt_r.pilot = 3'b100;
          nxt_r.st    = att_pkg::ATT_LO;
        end
        else if (r_ff.tmr == att_pkg::T_CLOSE_MS)
          abort = 1'b1;
      att_pkg::ATT_LO:
        if (wexp && !extend)
        begin
          if (in_band(pos_int, r_ff.tc, r_ff.tol))
          begin
            abort = 1'b1;
            wrong = 1'b1;
          end
          else
          begin
            nxt_r.td        = pos_int;
            nxt_r.taught[3] = 1'b1;
            nxt_r.pilot     = 3'b000;
            nxt_r.st        = att_pkg::ATT_CL3;
          end
        end
      att_pkg::ATT_CL3:
        if (closed)
        begin
          nxt_r.st          = att_pkg::ATT_IDLE;
          ev[att_pkg::EV_DONE] = 1'b1;
        end
        else if (r_ff.tmr == att_pkg::T_CLOSE_MS)
          abort = 1'b1;
      default:
        nxt_r.st = att_pkg::ATT_IDLE;
    endcase
    if (abort)
    begin
      nxt_r.st     = att_pkg::ATT_IDLE;
      nxt_r.pilot  = 3'b000;
      nxt_r.taught = 4'h0;
      nxt_r.ta     = '0;
      nxt_r.tb     = '0;
      nxt_r.tc     = '0;
      nxt_r.td     = '0;
      nxt_r.err    = 1'b1;
      ev[att_pkg::EV_TMO]   = !wrong;
      ev[att_pkg::EV_WRONG] = wrong;
    end
    else if (rst_req && !run)
    begin
      nxt_r.taught = 4'h0;
      nxt_r.ta     = '0;
      nxt_r.tb     = '0;
      nxt_r.tc     = '0;
      nxt_r.td     = '0;
      ev[att_pkg::EV_RESET] = 1'b1;
    end
    if (nxt_r.st != r_ff.st)
    begin
      nxt_r.tmr = 16'h0000;
      nxt_r.ext = 1'b0;
    end
    nxt_r.reach = {r_ff.taught[3] && in_band(pos_int, r_ff.td, r_ff.tol),
                   r_ff.taught[2] && in_band(pos_int, r_ff.tc, r_ff.tol),
                   r_ff.taught[1] && in_band(pos_ext, r_ff.tb, r_ff.tol),
                   r_ff.taught[0] && closed};
    nxt_r.vstate = r_ff.reach[0] ? 2'h1 : r_ff.reach[1] ? 2'h2
                 : (r_ff.reach[2] || r_ff.reach[3]) ? 2'h3 : 2'h0;
    if (tick)
      nxt_r.ledc = r_ff.ledc + 16'h0001;
    if (tick && r_ff.ledc >= per - 16'h0001)
    begin
      nxt_r.ledc = 16'h0000;
      nxt_r.ph   = (r_ff.ph == 2'h2) ? 2'h0 : r_ff.ph + 2'h1;
      nxt_r.bl   = !r_ff.bl;
    end
    if (r_ff.st != att_pkg::ATT_IDLE)
      nxt_r.led = 3'(3'b001 << r_ff.ph);
    else if (r_ff.taught == 4'h0)
      nxt_r.led = r_ff.bl ? 3'b001 : 3'b000;
    else
      nxt_r.led = 3'b100;
    if (reg_wr && reg_addr == att_pkg::OFF_TOL)
      nxt_r.tol = reg_wdata[SW-1:0];
    if (reg_wr && reg_addr == att_pkg::OFF_IEN)
      nxt_r.ien = reg_wdata[3:0];
    // New events win over a clear in the same cycle.
    nxt_r.ist   = (r_ff.ist & ~clr) | ev;
    nxt_r.rdata = 32'h0000_0000;
    if (reg_rd)
      case (reg_addr)
        att_pkg::OFF_STATUS: nxt_r.rdata = {12'h000, r_ff.err, r_ff.pilot, r_ff.reach,
                                            r_ff.taught, r_ff.st};
        att_pkg::OFF_TOL:    nxt_r.rdata = 32'(r_ff.tol);
        att_pkg::OFF_ISTAT:  nxt_r.rdata = {28'h000_0000, r_ff.ist};
        att_pkg::OFF_IEN:    nxt_r.rdata = {28'h000_0000, r_ff.ien};
        att_pkg::OFF_TGT_A:  nxt_r.rdata = 32'(r_ff.ta);
        att_pkg::OFF_TGT_B:  nxt_r.rdata = 32'(r_ff.tb);
        att_pkg::OFF_TGT_C:  nxt_r.rdata = 32'(r_ff.tc);
        att_pkg::OFF_TGT_D:  nxt_r.rdata = 32'(r_ff.td);
        default:             nxt_r.rdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_ff       <= '0;
      r_ff.st    <= att_pkg::ATT_IDLE;
      r_ff.tol   <= SW'(att_pkg::TOL_RST);
    end
    else
      r_ff <= nxt_r;
  end

  assign reg_rdata        = r_ff.rdata;
  assign pilot_output_a   = r_ff.pilot[0];
  assign pilot_output_b   = r_ff.pilot[1];
  assign pilot_output_c   = r_ff.pilot[2];
  assign target_pos_a     = r_ff.reach[0];
  assign target_pos_b     = r_ff.reach[1];
  assign target_pos_c     = r_ff.reach[2];
  assign target_pos_d     = r_ff.reach[3];
  assign valve_state      = r_ff.vstate;
  assign status_indicator = r_ff.led;
  assign irq              = |(r_ff.ist & r_ff.ien);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_mode_entry;
    $rose(r_ff.st == att_pkg::ATT_ARMED) |-> $past(mode_req);
  endproperty
  a_mode_entry: assert property (p_mode_entry)
    else $error("Autotune mode entered without a request.");

  property p_start;
    $rose(r_ff.st == att_pkg::ATT_OPEN) |-> $past(start_req)
      && r_ff.pilot == 3'b001 && r_ff.taught == 4'h1 && r_ff.ta == $past(pos_ext);
  endproperty
  a_start: assert property (p_start)
    else $error("Teach start did not latch closed target.");

  property p_arm_tmo;
    r_ff.st == att_pkg::ATT_ARMED && r_ff.tmr == att_pkg::T_ARM_MS
      |=> r_ff.st == att_pkg::ATT_IDLE;
  endproperty
  a_arm_tmo: assert property (p_arm_tmo)
    else $error("Autotune mode outlived its timeout.");

  property p_extend;
    r_ff.st == att_pkg::ATT_OPEN && extend
      |=> r_ff.st == att_pkg::ATT_OPEN && r_ff.ext && r_ff.tmr == 16'h0000;
  endproperty
  a_extend: assert property (p_extend)
    else $error("Wait not extended on motion.");

  property p_single;
    r_ff.st == att_pkg::ATT_CL1 && closed && r_ff.vt_s2 == att_pkg::SINGLE_SEAT
      |=> r_ff.st == att_pkg::ATT_IDLE && r_ff.ist[att_pkg::EV_DONE];
  endproperty
  a_single: assert property (p_single)
    else $error("Single-seat teach did not finish.");

  property p_upper;
    r_ff.st == att_pkg::ATT_UP |-> r_ff.pilot == 3'b010;
  endproperty
  a_upper: assert property (p_upper)
    else $error("Wrong pilot during upper seat step.");

  property p_lower;
    r_ff.st == att_pkg::ATT_LO |-> r_ff.pilot == 3'b100;
  endproperty
  a_lower: assert property (p_lower)
    else $error("Wrong pilot during lower seat step.");

  property p_close_tmo;
    closing && !closed && r_ff.tmr == att_pkg::T_CLOSE_MS
      |=> r_ff.st == att_pkg::ATT_IDLE && r_ff.ist[att_pkg::EV_TMO];
  endproperty
  a_close_tmo: assert property (p_close_tmo)
    else $error("Closure timeout did not abort.");

  property p_abort_clear;
    $rose(r_ff.err) |-> r_ff.taught == 4'h0 && r_ff.pilot == 3'b000 ##1 r_ff.led != 3'b100;
  endproperty
  a_abort_clear: assert property (p_abort_clear)
    else $error("Abort left targets or pilots set.");

  property p_reset;
    rst_req && !run |=> r_ff.taught == 4'h0 && r_ff.ist[att_pkg::EV_RESET];
  endproperty
  a_reset: assert property (p_reset)
    else $error("Teach reset did not clear targets.");

  property p_reach;
    target_pos_a |-> $past(r_ff.taught[0]);
  endproperty
  a_reach: assert property (p_reach)
    else $error("Untaught target reported reached.");

  property p_led;
    r_ff.st == att_pkg::ATT_ARMED && $past(r_ff.st == att_pkg::ATT_ARMED)
      |-> $onehot(status_indicator);
  endproperty
  a_led: assert property (p_led)
    else $error("Indicator not cycling in autotune mode.");

  c_double_done: cover property ($rose(r_ff.st == att_pkg::ATT_CL3)
                                 ##[1:300] r_ff.st == att_pkg::ATT_IDLE);
  c_single_done: cover property (r_ff.st == att_pkg::ATT_CL1 ##1 r_ff.st == att_pkg::ATT_IDLE);
  c_wrong:       cover property ($rose(r_ff.ist[att_pkg::EV_WRONG]));
  c_reset:       cover property ($rose(r_ff.ist[att_pkg::EV_RESET]));

endmodule : att_sequencer

// >>> tb/att_valve_model.sv
// Behavioural pilot valve and position sensor model.
`timescale 1ns/1ps
module att_valve_model (
  // Clock and reset.
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  // Pilot drives and fault controls.
  input  wire logic  pilot_a,
  input  wire logic  pilot_b,
  input  wire logic  pilot_c,
  input  wire logic  stuck,
  input  wire logic  same_seat,
  // Sensor readings.
  output logic [9:0] pos_ext,
  output logic [9:0] pos_int
);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pos_ext <= 10'h064;
      pos_int <= 10'h032;
    end
    else
    begin
      // A stuck stem stays open after its pilot drops.
      pos_ext <= (pilot_a || (stuck && pos_ext == 10'h190)) ? 10'h190 : 10'h064;
      pos_int <= pilot_b ? 10'h0C8 : pilot_c ? (same_seat ? 10'h0C8 : 10'h15E) : 10'h032;
    end
  end
endmodule : att_valve_model

// >>> tb/att_sequencer_bench.sv
// Self-checking bench of the autotune teach sequencer.
`timescale 1ns/1ps
module att_sequencer_bench;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        teach_button_a = 1'b0;
  logic        teach_button_b = 1'b0;
  logic        teach_button_c = 1'b0;
  logic        valve_type_switch_lo = 1'b0;
  logic        valve_type_switch_hi = 1'b0;
  logic        stuck = 1'b0;
  logic        same_seat = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rdat;
  logic [9:0]  pos_ext;
  logic [9:0]  pos_int;
  logic        pilot_output_a, pilot_output_b, pilot_output_c;
  logic        target_pos_a, target_pos_b, target_pos_c, target_pos_d;
  logic [1:0]  valve_state;
  logic [2:0]  status_indicator;
  logic        irq;
  logic        seen_b = 1'b0;
  logic        seen_c = 1'b0;
  int          num_errors = 0;
  int          num_checks = 0;

  att_sequencer #(.SW(10), .TICK_CYC(1)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .teach_button_a(teach_button_a),
    .teach_button_b(teach_button_b), .teach_button_c(teach_button_c),
    .valve_type_switch_lo(valve_type_switch_lo), .valve_type_switch_hi(valve_type_switch_hi),
    .pos_ext(pos_ext), .pos_int(pos_int), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pilot_output_a(pilot_output_a), .pilot_output_b(pilot_output_b),
    .pilot_output_c(pilot_output_c), .target_pos_a(target_pos_a),
    .target_pos_b(target_pos_b), .target_pos_c(target_pos_c), .target_pos_d(target_pos_d),
    .valve_state(valve_state), .status_indicator(status_indicator), .irq(irq));

  att_valve_model valve (
    .clk_sys(clk_sys), .rst_n(rst_n), .pilot_a(pilot_output_a), .pilot_b(pilot_output_b),
    .pilot_c(pilot_output_c), .stuck(stuck), .same_seat(same_seat),
    .pos_ext(pos_ext), .pos_int(pos_int));

  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    if (pilot_output_b === 1'b1) seen_b <= 1'b1;
    if (pilot_output_c === 1'b1) seen_c <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // Let the write settle before any caller samples an output.
    #1;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rdat = reg_rdata;
    chk(rdat & m, e, "register read");
  endtask : rdchk

  task automatic press(input logic [2:0] abc, input int ms);
    @(posedge clk_sys);
    {teach_button_a, teach_button_b, teach_button_c} <= abc;
    repeat (ms) @(posedge clk_sys);
    {teach_button_a, teach_button_b, teach_button_c} <= 3'h0;
    repeat (50) @(posedge clk_sys);
  endtask : press

  // Polls the state field until the sequencer is idle again.
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    rdchk(att_pkg::OFF_STATUS, 32'h0, 32'h0);
    while (rdat[7:0] !== 8'h01 && n < lim)
    begin
      repeat (98) @(posedge clk_sys);
      rdchk(att_pkg::OFF_STATUS, 32'h0, 32'h0);
      n += 100;
    end
    chk({24'h0, rdat[7:0]}, 32'h1, "idle state");
  endtask : wait_idle

  task automatic print_verdict();
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (115000) @(posedge clk_sys);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(att_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h1);
    rdchk(att_pkg::OFF_TOL, 32'hFFFFFFFF, 32'h8);
    rdchk(att_pkg::OFF_ISTAT, 32'hFFFFFFFF, 32'h0);
    rdchk(att_pkg::OFF_IEN, 32'hFFFFFFFF, 32'h0);
    rdchk(8'h3C, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, valve_state}, 32'h0, "valve state");
    $display("Test reset done");
    press(3'h3, 2000);
    rdchk(att_pkg::OFF_STATUS, 32'hFF, 32'h01);
    press(3'h3, 2600);
    rdchk(att_pkg::OFF_STATUS, 32'hFF, 32'h02);
    chk({31'h0, $onehot(status_indicator)}, 32'h1, "armed colour");
    repeat (10500) @(posedge clk_sys);
    rdchk(att_pkg::OFF_STATUS, 32'hFF, 32'h01);
    $display("Test mode timeout done");
    wr(att_pkg::OFF_IEN, 32'h1);
    press(3'h3, 2600);
    press(3'h4, 600);
    chk({31'h0, pilot_output_a}, 32'h1, "pilot a");
    rdchk(att_pkg::OFF_STATUS, 32'hFFF, 32'h104);
    chk({31'h0, $onehot(status_indicator)}, 32'h1, "run colour");
    wait_idle(40000);
    chk({31'h0, seen_b & seen_c}, 32'h1, "seat pilots");
    rdchk(att_pkg::OFF_STATUS, 32'hFFFFF, 32'h01F01);
    rdchk(att_pkg::OFF_TGT_A, 32'h3FF, 32'h064);
    rdchk(att_pkg::OFF_TGT_B, 32'h3FF, 32'h190);
    rdchk(att_pkg::OFF_TGT_C, 32'h3FF, 32'h0C8);
    rdchk(att_pkg::OFF_TGT_D, 32'h3FF, 32'h15E);
    rdchk(att_pkg::OFF_ISTAT, 32'hF, 32'h1);
    chk({31'h0, irq}, 32'h1, "irq raised");
    chk({29'h0, target_pos_a, valve_state}, 32'h5, "closed state");
    wr(att_pkg::OFF_ICLR, 32'hF);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("Test double seat done");
    press(3'h6, 2600);
    rdchk(att_pkg::OFF_STATUS, 32'hF00, 32'h0);
    rdchk(att_pkg::OFF_ISTAT, 32'hF, 32'h8);
    chk({31'h0, irq}, 32'h0, "irq masked");
    $display("Test teach reset done");
    wr(att_pkg::OFF_ICLR, 32'hF);
    same_seat <= 1'b1;
    wr(att_pkg::OFF_CTRL, 32'h1);
    wr(att_pkg::OFF_CTRL, 32'h2);
    wait_idle(40000);
    rdchk(att_pkg::OFF_ISTAT, 32'hF, 32'h4);
    rdchk(att_pkg::OFF_STATUS, 32'hFFF00, 32'h80000);
    chk({29'h0, status_indicator & 3'h6}, 32'h0, "fault colour");
    $display("Test wrong selection done");
    wr(att_pkg::OFF_ICLR, 32'hF);
    same_seat <= 1'b0;
    stuck <= 1'b1;
    valve_type_switch_hi <= 1'b1;
    wr(att_pkg::OFF_CTRL, 32'h1);
    wr(att_pkg::OFF_CTRL, 32'h2);
    wait_idle(30000);
    rdchk(att_pkg::OFF_ISTAT, 32'hF, 32'h2);
    rdchk(att_pkg::OFF_STATUS, 32'hFFF00, 32'h80000);
    chk({29'h0, status_indicator & 3'h6}, 32'h0, "fault colour");
    wr(att_pkg::OFF_ICLR, 32'hF);
    wr(att_pkg::OFF_CTRL, 32'h4);
    rdchk(att_pkg::OFF_ISTAT, 32'hF, 32'h8);
    $display("Test closure timeout done");
    print_verdict();
  end
endmodule : att_sequencer_bench
